// ==== ssp_map.svh ====
// register map, field positions, reset values and timing of the serial port pin block
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SSP_OFF_PORT_CTRL 8'h00
`define SSP_OFF_PORT_DIR  8'h04
`define SSP_OFF_PORT_DATA 8'h08
`define SSP_OFF_MODE      8'h0C
`define SSP_OFF_TX0       8'h10
`define SSP_OFF_TX1       8'h14
`define SSP_OFF_TX2       8'h18
`define SSP_OFF_RX        8'h1C
`define SSP_OFF_STATUS    8'h20

// ----------------------------------------
// pin indices
// ----------------------------------------
`define SSP_PIN_LINE_A 0
`define SSP_PIN_LINE_B 1
`define SSP_PIN_FS     2
`define SSP_PIN_SCK    3
`define SSP_PIN_RXD    4
`define SSP_PIN_TXD    5
`define SSP_PIN_N      6

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define SSP_MODE_SYNC    0
`define SSP_MODE_SCK_OUT 1
`define SSP_MODE_FS_OUT  2
`define SSP_MODE_RCK_OUT 3
`define SSP_MODE_RFS_OUT 4
`define SSP_MODE_A_FLAG  5
`define SSP_MODE_B_FLAG  6
`define SSP_MODE_EN      7
`define SSP_MODE_STOP    8
`define SSP_MODE_WAIT    9
`define SSP_MODE_FLAG0   10
`define SSP_MODE_FLAG1   11
`define SSP_MODE_DIV_LO  16
`define SSP_MODE_DIV_HI  23
`define SSP_MODE_W       24

// ----------------------------------------
// reset values, widths, timing
// ----------------------------------------
`define SSP_PIN_RESET  6'h00
`define SSP_MODE_RESET 24'h04_0000
`define SSP_WORD_W     8
`define SSP_BIT_LAST   3'h7
// least half period of the bit clock in system cycles
`define SSP_HALF_MIN   8'h03

`endif

// ==== ssp_pkg.sv ====
// types shared by the serial port pin block
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_IDLE  = 2'b00,
    SSP_SHIFT = 2'b01
  } ssp_frame_t;
endpackage : ssp_pkg

// ==== ssp_pin_sync.sv ====
// two-stage synchronisers and edge detection for the port pins
`timescale 1ns/10ps
`include "ssp_map.svh"
module ssp_pin_sync (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic [`SSP_PIN_N-1:0]  pinIn,
  output logic      [`SSP_PIN_N-1:0]  level,
  output logic      [`SSP_PIN_N-1:0]  rise,
  output logic      [`SSP_PIN_N-1:0]  fall
);
  logic [`SSP_PIN_N-1:0] meta;
  logic [`SSP_PIN_N-1:0] prev;

  // ----------------------------------------
  // per-pin stages
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `SSP_PIN_N; i = i + 1) begin : g_pin
      always_ff @(posedge clk) begin
        if (srst) begin
          meta[i]  <= 1'b0;
          level[i] <= 1'b0;
          prev[i]  <= 1'b0;
        end else begin
          meta[i]  <= pinIn[i];
          level[i] <= meta[i];
          prev[i]  <= level[i];
        end
      end
      assign rise[i] = level[i] & ~prev[i];
      assign fall[i] = ~level[i] & prev[i];
    end
  endgenerate
endmodule : ssp_pin_sync

// ==== ssp_shift_word.sv ====
// one serial shift register, msb first
`timescale 1ns/10ps
`include "ssp_map.svh"
module ssp_shift_word (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    load,
  input  wire logic                    shift,
  input  wire logic [`SSP_WORD_W-1:0]  loadWord,
  input  wire logic                    serialIn,
  output logic      [`SSP_WORD_W-1:0]  word,
  output logic                         msb
);
  assign msb = word[`SSP_WORD_W-1];

  always_ff @(posedge clk) begin
    if (srst) begin
      word <= '0;
    end else if (load) begin
      word <= loadWord;
    end else if (shift) begin
      word <= {word[`SSP_WORD_W-2:0], serialIn};
    end
  end
endmodule : ssp_shift_word

// ==== ssp_port_pins.sv ====
// serial port pin mux, bit clock, framing and register slave
`timescale 1ns/10ps
`include "ssp_map.svh"
module ssp_port_pins
  import ssp_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [`SSP_PIN_N-1:0]  pinIn,
  output logic      [`SSP_PIN_N-1:0]  pinOut,
  output logic      [`SSP_PIN_N-1:0]  pinOe
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [`SSP_PIN_N-1:0]   portControl;
  logic [`SSP_PIN_N-1:0]   pinDir;
  logic [`SSP_PIN_N-1:0]   gpioData;
  logic [`SSP_MODE_W-1:0]  modeCfg;
  logic [`SSP_WORD_W-1:0]  txWord [0:2];
  logic [`SSP_WORD_W-1:0]  rxWord;
  logic                    txEmpty;
  logic                    rxFull;

  function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : regHit

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire access  = psel & penable & ~pready;
  wire wrEn    = access & pwrite;
  wire rdEn    = access & ~pwrite;
  wire hitCtrl = regHit(paddr, `SSP_OFF_PORT_CTRL);
  wire hitDir  = regHit(paddr, `SSP_OFF_PORT_DIR);
  wire hitData = regHit(paddr, `SSP_OFF_PORT_DATA);
  wire hitMode = regHit(paddr, `SSP_OFF_MODE);
  wire hitTx0  = regHit(paddr, `SSP_OFF_TX0);
  wire hitTx1  = regHit(paddr, `SSP_OFF_TX1);
  wire hitTx2  = regHit(paddr, `SSP_OFF_TX2);
  wire hitRx   = regHit(paddr, `SSP_OFF_RX);
  wire hitStat = regHit(paddr, `SSP_OFF_STATUS);
  wire anyHit  = hitCtrl | hitDir | hitData | hitMode | hitTx0 | hitTx1
               | hitTx2 | hitRx | hitStat;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [`SSP_PIN_N-1:0] pinLevel;
  logic [`SSP_PIN_N-1:0] pinRise;
  logic [`SSP_PIN_N-1:0] pinFall;

  ssp_pin_sync u_sync (
    .clk   (clk),
    .srst  (srst),
    .pinIn (pinIn),
    .level (pinLevel),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire syncMode = modeCfg[`SSP_MODE_SYNC];
  wire sckOut   = modeCfg[`SSP_MODE_SCK_OUT];
  wire fsOut    = modeCfg[`SSP_MODE_FS_OUT];
  wire rckOut   = modeCfg[`SSP_MODE_RCK_OUT];
  wire rfsOut   = modeCfg[`SSP_MODE_RFS_OUT];
  wire aFlag    = modeCfg[`SSP_MODE_A_FLAG];
  wire bFlag    = modeCfg[`SSP_MODE_B_FLAG];
  wire stopped  = modeCfg[`SSP_MODE_STOP];
  wire running  = modeCfg[`SSP_MODE_EN] & ~stopped;
  wire [7:0] divField = modeCfg[`SSP_MODE_DIV_HI:`SSP_MODE_DIV_LO];
  // own clock never below six cycles
  wire [7:0] halfDiv  = (divField < `SSP_HALF_MIN) ? `SSP_HALF_MIN : divField;

  // ----------------------------------------
  // internal bit clock divider
  // ----------------------------------------
  logic [7:0] divCnt;
  logic       intSck;
  wire        divTick = running & (divCnt == halfDiv - 8'h01);
  wire        intRise = divTick & ~intSck;
  wire        intFall = divTick & intSck;

  always_ff @(posedge clk) begin
    if (srst | ~running) begin
      divCnt <= 8'h00;
      intSck <= 1'b0;
    end else if (divTick) begin
      divCnt <= 8'h00;
      intSck <= ~intSck;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  // ----------------------------------------
  // clock and frame sync selection
  // ----------------------------------------
  logic fsInt;
  wire txRise = running & (sckOut ? intRise : pinRise[`SSP_PIN_SCK]);
  wire txFall = running & (sckOut ? intFall : pinFall[`SSP_PIN_SCK]);
  wire rxFallA = rckOut ? intFall : pinFall[`SSP_PIN_LINE_A];
  wire rxFall = running & (syncMode ? txFall : rxFallA);
  wire txFs   = fsOut ? 1'b1 : pinLevel[`SSP_PIN_FS];
  // receive frame sync on line b
  wire rxFsA  = rfsOut ? fsInt : pinLevel[`SSP_PIN_LINE_B];
  wire rxFs   = syncMode ? (fsOut ? fsInt : pinLevel[`SSP_PIN_FS]) : rxFsA;

  // ----------------------------------------
  // transmit framing
  // ----------------------------------------
  ssp_frame_t txState;
  logic [2:0] txBit;
  wire        txActive = (txState == SSP_SHIFT);
  wire        txLast   = txActive & (txBit == `SSP_BIT_LAST);
  wire        txStart  = txRise & txFs & (~txActive | txLast);
  wire        txShift  = txRise & txActive & ~txLast;
  logic [2:0] txMsb;

  always_ff @(posedge clk) begin
    if (srst) begin
      txState <= SSP_IDLE;
      txBit   <= 3'h0;
      fsInt   <= 1'b0;
    end else if (txStart) begin
      txState <= SSP_SHIFT;
      txBit   <= 3'h0;
      fsInt   <= fsOut;
    end else if (txRise) begin
      fsInt <= 1'b0;
      if (txLast) begin
        txState <= SSP_IDLE;
      end else if (txActive) begin
        txBit <= txBit + 3'h1;
      end
    end
  end

  genvar t;
  generate
    for (t = 0; t < 3; t = t + 1) begin : g_tx
      ssp_shift_word u_tx (
        .clk      (clk),
        .srst     (srst),
        .load     (txStart),
        .shift    (txShift),
        .loadWord (txWord[t]),
        .serialIn (1'b0),
        .word     (),
        .msb      (txMsb[t])
      );
    end
  endgenerate

  // ----------------------------------------
  // receive framing
  // ----------------------------------------
  ssp_frame_t rxState;
  logic [2:0] rxBit;
  logic [`SSP_WORD_W-1:0] rxShWord;
  wire rxActive = (rxState == SSP_SHIFT);
  wire rxTake   = rxFall & (rxActive | rxFs);
  wire rxDone   = rxFall & rxActive & (rxBit == `SSP_BIT_LAST);

  ssp_shift_word u_rx (
    .clk      (clk),
    .srst     (srst),
    .load     (1'b0),
    .shift    (rxTake),
    .loadWord ('0),
    .serialIn (pinLevel[`SSP_PIN_RXD]),
    .word     (rxShWord),
    .msb      ()
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      rxState <= SSP_IDLE;
      rxBit   <= 3'h0;
    end else if (rxDone) begin
      rxState <= SSP_IDLE;
    end else if (rxTake) begin
      rxState <= SSP_SHIFT;
      rxBit   <= rxActive ? rxBit + 3'h1 : 3'h1;
    end
  end

  // ----------------------------------------
  // register writes and flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      portControl <= `SSP_PIN_RESET;
      pinDir      <= `SSP_PIN_RESET;
      gpioData    <= `SSP_PIN_RESET;
      modeCfg     <= `SSP_MODE_RESET;
    end else if (wrEn) begin
      if (hitCtrl) portControl <= pwdata[`SSP_PIN_N-1:0];
      if (hitDir)  pinDir      <= pwdata[`SSP_PIN_N-1:0];
      if (hitData) gpioData    <= pwdata[`SSP_PIN_N-1:0];
      if (hitMode) modeCfg     <= pwdata[`SSP_MODE_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      txWord[0] <= '0;
      txWord[1] <= '0;
      txWord[2] <= '0;
    end else if (wrEn) begin
      if (hitTx0) txWord[0] <= pwdata[`SSP_WORD_W-1:0];
      if (hitTx1) txWord[1] <= pwdata[`SSP_WORD_W-1:0];
      if (hitTx2) txWord[2] <= pwdata[`SSP_WORD_W-1:0];
    end
  end

  // set wins over clear on both flags
  always_ff @(posedge clk) begin
    if (srst) begin
      txEmpty <= 1'b1;
      rxFull  <= 1'b0;
      rxWord  <= '0;
    end else begin
      if (txStart) txEmpty <= 1'b1;
      else if (wrEn & hitTx0) txEmpty <= 1'b0;
      if (rxDone) begin
        rxFull <= 1'b1;
        rxWord <= {rxShWord[`SSP_WORD_W-2:0], pinLevel[`SSP_PIN_RXD]};
      end else if (rdEn & hitRx) begin
        rxFull <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read mux and bus answer
  // ----------------------------------------
  wire [31:0] statWord = {18'h0_0000, pinLevel, 4'h0, rxActive, txActive, rxFull, txEmpty};
  wire [31:0] readWord =
      hitCtrl ? {26'h000_0000, portControl} :
      hitDir  ? {26'h000_0000, pinDir} :
      hitData ? {26'h000_0000, pinLevel} :
      hitMode ? {8'h00, modeCfg} :
      hitTx0  ? {24'h00_0000, txWord[0]} :
      hitTx1  ? {24'h00_0000, txWord[1]} :
      hitTx2  ? {24'h00_0000, txWord[2]} :
      hitRx   ? {24'h00_0000, rxWord} :
      hitStat ? statWord : 32'h0000_0000;

  // one wait state, answer registered
  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & ~anyHit;
      prdata  <= rdEn ? readWord : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // serial function per pin
  // ----------------------------------------
  logic [`SSP_PIN_N-1:0] fnOut;
  logic [`SSP_PIN_N-1:0] fnOe;
  // line a as transmitter one or flag
  wire aSyncOut = aFlag ? modeCfg[`SSP_MODE_FLAG0] : txMsb[1];
  wire aSyncOe  = aFlag ? pinDir[`SSP_PIN_LINE_A] : txActive;
  // line b as transmitter two or flag
  wire bSyncOut = bFlag ? modeCfg[`SSP_MODE_FLAG1] : txMsb[2];
  wire bSyncOe  = bFlag ? pinDir[`SSP_PIN_LINE_B] : txActive;

  // async line a is receive clock
  assign fnOut[`SSP_PIN_LINE_A] = syncMode ? aSyncOut : intSck;
  assign fnOe[`SSP_PIN_LINE_A]  = syncMode ? aSyncOe : rckOut;
  // async line b is receive frame sync
  assign fnOut[`SSP_PIN_LINE_B] = syncMode ? bSyncOut : fsInt;
  assign fnOe[`SSP_PIN_LINE_B]  = syncMode ? bSyncOe : rfsOut;
  assign fnOut[`SSP_PIN_FS]     = fsInt;
  assign fnOe[`SSP_PIN_FS]      = fsOut;
  assign fnOut[`SSP_PIN_SCK]    = intSck;
  assign fnOe[`SSP_PIN_SCK]     = sckOut;
  assign fnOut[`SSP_PIN_RXD]    = 1'b0;
  assign fnOe[`SSP_PIN_RXD]     = 1'b0;
  assign fnOut[`SSP_PIN_TXD]    = txMsb[0];
  assign fnOe[`SSP_PIN_TXD]     = txActive;

  wire [`SSP_PIN_N-1:0] nextPinOut = (portControl & fnOut) | (~portControl & gpioData);
  wire [`SSP_PIN_N-1:0] nextPinOe  = (portControl & fnOe) | (~portControl & pinDir);

  // wait bit has no effect on pins
  always_ff @(posedge clk) begin
    if (srst) begin
      pinOut <= `SSP_PIN_RESET;
      pinOe  <= `SSP_PIN_RESET;
    end else if (stopped) begin
      pinOe <= `SSP_PIN_RESET;
    end else begin
      pinOut <= nextPinOut;
      pinOe  <= nextPinOe;
    end
  end
endmodule : ssp_port_pins

// ==== ssp_port_pins_sva.sv ====
// assertions on the ports of the serial port pin block
`timescale 1ns/10ps
`include "ssp_map.svh"
module ssp_port_pins_chk (
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [`SSP_PIN_N-1:0] pinIn,
  input wire logic [`SSP_PIN_N-1:0] pinOut,
  input wire logic [`SSP_PIN_N-1:0] pinOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  access_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  refusal_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without ready or with data");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  // ----------------------------------------
  // pins
  // ----------------------------------------
  reset_quiet_a: assert property ($fell(srst) |-> pinOe == 6'h00 && pinOut == 6'h00)
    else $error("pins driven after reset");
  dir_write_a: assert property ($changed(pinOe[4]) |->
    ($past(pready) && $past(pwrite)) || ($past(pready, 2) && $past(pwrite, 2)))
    else $error("rx pin direction changed without write");
  // half period of a bit clock at least three cycles
  sck_half_a: assert property (pinOe[3] && $changed(pinOut[3]) |=> $stable(pinOut[3]) [*2])
    else $error("bit clock half period too short");
  tx_hold_a: assert property (pinOe[5] && $changed(pinOut[5]) |=> $stable(pinOut[5]) [*4])
    else $error("tx bit not held");
  fs_width_a: assert property (pinOe[2] && $rose(pinOut[2]) |=> pinOut[2] [*4])
    else $error("frame sync too short");
  cover property (pslverr);
  cover property (pinOe[5] && $rose(pinOut[2]));
  cover property (pinOe[3] && $rose(pinOut[3]));
endmodule : ssp_port_pins_chk

// ==== ssp_codec_model.sv ====
// far-side codec: bit clock, frame sync and rx data source, tx data sink
`timescale 1ns/10ps
module ssp_codec_model (
  input  wire logic       start,
  input  wire logic [7:0] sendByte,
  input  wire logic [5:0] gpioVal,
  input  wire logic [5:0] lvl,
  output logic      [5:0] drv,
  output logic      [7:0] gotByte,
  output logic      [7:0] frames
);
  logic       ckDrv;
  logic       fsDrv;
  logic       rdDrv;
  logic [7:0] sr;
  int         n;

  assign drv = {gpioVal[5], rdDrv, ckDrv, fsDrv, gpioVal[1:0]};

  initial begin
    ckDrv = 1'b0;
    fsDrv = 1'b0;
    rdDrv = 1'b0;
    sr = 8'h00;
    n = 8;
    gotByte = 8'h00;
    frames = 8'h00;
  end

  // period 320 ns
  // long high half: sync latency of the port eats into it
  always @(posedge start) begin
    for (int i = 0; i < 8; i++) begin
      ckDrv = 1'b1;
      fsDrv = (i == 0);
      rdDrv = sendByte[7-i];
      #200;
      ckDrv = 1'b0;
      #120;
    end
    fsDrv = 1'b0;
    // hold over: line no longer valid
    rdDrv = ~rdDrv;
  end

  // frame sync high at a fall marks the first bit, msb first
  always @(negedge lvl[3]) begin
    if (lvl[2] === 1'b1) n = 0;
    if (n < 8) begin
      sr = {sr[6:0], lvl[5]};
      n++;
      if (n == 8) begin
        gotByte = sr;
        frames = frames + 8'h01;
      end
    end
  end
endmodule : ssp_codec_model

// ==== ssp_tb.sv ====
// self-checking bench of the serial port pin block
`timescale 1ns/10ps
`include "ssp_map.svh"
module tb;
  logic        clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  pinIn;
  logic [5:0]  pinOut;
  logic [5:0]  pinOe;
  logic [5:0]  drv;
  logic [5:0]  gpioVal;
  logic        start;
  logic [7:0]  sendByte;
  logic [7:0]  gotByte;
  logic [7:0]  frames;
  logic [31:0] rdv;
  logic        errv;
  int          nMismatch;
  int          checkCount;

  // wire level: whoever enables drives
  assign pinIn = (pinOe & pinOut) | (~pinOe & drv);

  ssp_port_pins uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  ssp_codec_model uFar (.start(start), .sendByte(sendByte), .gpioVal(gpioVal),
    .lvl(pinIn), .drv(drv), .gotByte(gotByte), .frames(frames));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk32(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checkCount++;
    if (got !== ex) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk32

  task automatic chk6(input string nm, input logic [5:0] ex, input logic [5:0] got);
    checkCount++;
    if (got !== ex) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk6

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) nMismatch++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk32(nm, ex, rdv);
  endtask : rd

  // outputs are registered: let the write settle first
  task automatic pins(input logic [5:0] oe, input logic [5:0] out, input logic [5:0] m);
    repeat (3) @(posedge clk);
    chk6("pinOe", oe, pinOe);
    chk6("pinOut", out & m, pinOut & m);
  endtask : pins

  task automatic waitFrame;
    logic [7:0] snap;
    int         n;
    snap = frames;
    n = 0;
    while (frames === snap && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) nMismatch++;
  endtask : waitFrame

  task automatic conclude;
    if (nMismatch == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  initial begin
    #800000;
    nMismatch++;
    conclude();
  end

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    start = 1'b0;
    sendByte = 8'h3C;
    gpioVal = 6'h20;
    nMismatch = 0;
    checkCount = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    pins(6'h00, 6'h00, 6'h3F);
    rd(`SSP_OFF_PORT_CTRL, 32'h0000_0000, "ctrl");
    rd(`SSP_OFF_PORT_DIR, 32'h0000_0000, "dir");
    rd(`SSP_OFF_MODE, 32'h0004_0000, "mode");
    rd(`SSP_OFF_STATUS, 32'h0000_2001, "status");
    apb(1'b1, `SSP_OFF_PORT_DIR, 32'h0000_001F);
    apb(1'b1, `SSP_OFF_PORT_DATA, 32'h0000_0005);
    pins(6'h1F, 6'h05, 6'h1F);
    rd(`SSP_OFF_PORT_DATA, 32'h0000_0025, "pinLevel");
    apb(1'b1, `SSP_OFF_MODE, 32'h0004_0200);
    pins(6'h1F, 6'h05, 6'h1F);
    apb(1'b1, `SSP_OFF_MODE, 32'h0004_0100);
    pins(6'h00, 6'h05, 6'h1F);
    rd(8'h24, 32'h0000_0000, "unmappedData");
    chk32("unmappedErr", 32'h0000_0001, {31'h0, errv});
    apb(1'b1, `SSP_OFF_MODE, 32'h0003_04E1);
    apb(1'b1, `SSP_OFF_PORT_CTRL, 32'h0000_0003);
    apb(1'b1, `SSP_OFF_PORT_DIR, 32'h0000_0003);
    pins(6'h03, 6'h01, 6'h03);
    apb(1'b1, `SSP_OFF_MODE, 32'h0003_0CE1);
    pins(6'h03, 6'h03, 6'h03);
    // asynchronous: lines a and b carry own receive clock and frame sync
    apb(1'b1, `SSP_OFF_MODE, 32'h0003_0018);
    pins(6'h03, 6'h00, 6'h03);
    apb(1'b1, `SSP_OFF_MODE, 32'h0003_0000);
    pins(6'h00, 6'h00, 6'h03);
    // own bit clock and frame sync
    apb(1'b1, `SSP_OFF_PORT_CTRL, 32'h0000_003C);
    apb(1'b1, `SSP_OFF_TX0, 32'h0000_00A5);
    apb(1'b1, `SSP_OFF_MODE, 32'h0003_0087);
    waitFrame();
    waitFrame();
    chk32("ownTx", 32'h0000_00A5, {24'h0, gotByte});
    // external clock, both directions at once
    // mid-run reset: own frame never idles, a disable would leave it half sent
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    pins(6'h00, 6'h00, 6'h3F);
    apb(1'b1, `SSP_OFF_PORT_CTRL, 32'h0000_003C);
    apb(1'b0, `SSP_OFF_RX, 32'h0000_0000);
    apb(1'b1, `SSP_OFF_TX0, 32'h0000_005A);
    apb(1'b1, `SSP_OFF_MODE, 32'h0003_0081);
    start <= 1'b1;
    waitFrame();
    start <= 1'b0;
    chk32("extTx", 32'h0000_005A, {24'h0, gotByte});
    for (int i = 0; i < 20 && rdv[1] !== 1'b1; i++) apb(1'b0, `SSP_OFF_STATUS, 32'h0);
    rd(`SSP_OFF_RX, 32'h0000_003C, "rxWord");
    apb(1'b0, `SSP_OFF_STATUS, 32'h0000_0000);
    chk32("rxFullClear", 32'h0000_0000, {31'h0, rdv[1]});
    conclude();
  end
endmodule : tb

bind ssp_port_pins ssp_port_pins_chk uChk (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
